// ==== core/cqt_core.sv ====
/*
  Command sequencer: queue, field-timed execution, trigger line detection,
  event waits and steer value, all behind a classic Wishbone slave.
  Assumes synchronous inputs, one clock and a single bus master.
*/
// The register offsets and register access over Wishbone were chosen for this implementation.
// Overview of operation
// - Plain command waits for drain, acks after
// - Deferred command queued, acked at once
// - Only-if-idle fails when anything pending
// - Both flags: queue only when empty
// - Deferrable commands return a pollable handle
// - Configuration waits for whole queue drain
// - Output write and purge run at once, concurrently; line type write waits for idle
// - Field flags pick the starting field
// - One-field flag covers one field only
// - Flags independent; zero means plain default
// - Picture adjust ignores field flags
// - Trigger line reported at bit zero
// - Selectable rise, fall or level detection
// - Any-line wait pauses until one matches
// - All-line wait pauses until all match
// - Only masked lines are watched
// - Wait may watch the second board
// - Release loads steer if a watched line is active, clears matched states
// - Steer readable, steers capture and input
// - Reset clears steer value
// - Output write by mask, fails on zero
// - Output write with bit 16 set clears latched input state of masked lines
// - Purge drops queue, aborts running command
// - Reset aborts queue and line activity
module cqt_core (
  input  wire logic                  clk_i,           // System clock
  input  wire logic                  rst_i,           // Sync reset, high
  input  wire logic                  wb_cyc_i,        // Bus cycle
  input  wire logic                  wb_stb_i,        // Bus strobe
  input  wire logic                  wb_we_i,         // Write
  input  wire logic [7:0]            wb_adr_i,        // Byte address
  input  wire logic [3:0]            wb_sel_i,        // Byte lanes
  input  wire logic [31:0]           wb_dat_i,        // Write data
  output logic      [31:0]           wb_dat_o,        // Read data
  output logic                       wb_ack_o,        // Acknowledge
  input  wire logic [cqt_pkg::NL-1:0] trig_i,         // Trigger lines
  input  wire logic [cqt_pkg::NL-1:0] remote_state_i, // Other board state
  input  wire logic                  field_start_i,   // Field begins
  input  wire logic                  field_odd_i,     // Field is odd
  output logic                       capture_go_o,    // Capture start pulse
  output logic      [1:0]            capture_dest_o,  // Destination frame
  output logic                       capture_cont_o,  // Continuous capture
  output logic      [1:0]            cam_sel_o,       // Video input
  output logic      [7:0]            bright_o,        // Brightness
  output logic      [7:0]            contrast_o,      // Contrast
  output logic                       cfg_we_o,        // Config write pulse
  output logic      [3:0]            cfg_sel_o,       // Config item
  output logic      [7:0]            cfg_val_o,       // Config value
  output logic      [cqt_pkg::NL-1:0] out_line_o,     // Output lines
  output logic      [cqt_pkg::NL-1:0] remote_clr_o,   // Clear other board
  output logic                       busy_o           // Work pending
);
  localparam int EW = cqt_pkg::FLW + 4 + cqt_pkg::AW + cqt_pkg::HW;

  // ========================================================================
  // Functions
  // Byte lane mask from select
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Highest set line index
  function automatic logic [1:0] hi_line(input logic [cqt_pkg::NL-1:0] v);
    hi_line = 2'h0;
    for (int i = 0; i < cqt_pkg::NL; i++) begin
      if (v[i]) hi_line = i[1:0];
    end
  endfunction

  // ========================================================================
  // Declarations
  logic [EW-1:0]            q_mem [cqt_pkg::QD];
  logic [cqt_pkg::QAW-1:0]  wp_r, wp_nxt, rp_r, rp_nxt;
  logic [cqt_pkg::QAW:0]    cnt_r, cnt_nxt;
  logic                     ack_r, ack_nxt, dir_r, dir_nxt, busy_r;
  logic [31:0]              dat_r, dat_nxt, wd;
  logic [cqt_pkg::HW:0]     res_r, res_nxt;
  logic [cqt_pkg::HW-1:0]   hcnt_r, hcnt_nxt, done_r, done_nxt;
  logic [1:0]               ltype_r, ltype_nxt;
  logic [cqt_pkg::NL-1:0]   out_r, out_nxt, out_clr, eng_clr, line_st, omsk;
  logic                     acc, push, pop, start_dir, purge, pending, q_full;
  logic [3:0]               c_op;
  logic [cqt_pkg::FLW-1:0]  c_flg;
  cqt_pkg::cqt_eng_e        st_r, st_nxt;
  logic [EW-1:0]            ld, e_r, e_nxt;
  logic [3:0]               e_op;
  logic [cqt_pkg::FLW-1:0]  e_flg;
  logic [cqt_pkg::AW-1:0]   e_arg;
  logic [1:0]               fld_r, fld_nxt, steer_r, steer_nxt, dest_r, dest_nxt;
  logic [1:0]               cam_r, cam_nxt;
  logic                     go_r, go_nxt, cont_r, cont_nxt, cfgwe_r, cfgwe_nxt;
  logic [7:0]               bri_r, bri_nxt, con_r, con_nxt, cval_r, cval_nxt;
  logic [3:0]               csel_r, csel_nxt;
  logic [cqt_pkg::NL-1:0]   rclr_r, rclr_nxt, src, want, msk, sat, hits;
  logic                     released, fld_ok, adj;

  // ========================================================================
  // Trigger line detection, one per line
  generate
    for (genvar i = 0; i < cqt_pkg::NL; i++) begin : g_line
      logic prev_r, lst_r, lst_nxt, clr;
      // Set beats a same-cycle clear so no edge is lost
      always_comb begin
        clr = eng_clr[i] | out_clr[i];
        case (ltype_r)
          cqt_pkg::DT_RISE: lst_nxt = (trig_i[i] & ~prev_r) | (lst_r & ~clr);
          cqt_pkg::DT_FALL: lst_nxt = (~trig_i[i] & prev_r) | (lst_r & ~clr);
          default:          lst_nxt = trig_i[i];
        endcase
      end
      // Register, reset drops any latched activity
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          prev_r <= 1'b0;
          lst_r  <= 1'b0;
        end else begin
          prev_r <= trig_i[i];
          lst_r  <= lst_nxt;
        end
      end
      assign line_st[i] = lst_r;
    end
  endgenerate

  // ========================================================================
  // Bus slave and queue
  assign acc     = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wd      = wb_dat_i & lane_mask(wb_sel_i);
  assign c_op    = wd[cqt_pkg::OP_LSB +: 4];
  assign c_flg   = wd[cqt_pkg::FL_LSB +: cqt_pkg::FLW];
  assign pending = (cnt_r != '0) | (st_r != cqt_pkg::E_IDLE);
  assign q_full  = cnt_r == cqt_pkg::QD[cqt_pkg::QAW:0];
  assign pop     = (st_r == cqt_pkg::E_IDLE) & (cnt_r != '0) & ~purge;

  // Decode a request; stalls simply withhold ack
  always_comb begin
    ack_nxt = acc; dat_nxt = 32'h0; res_nxt = res_r; dir_nxt = dir_r;
    hcnt_nxt = hcnt_r; ltype_nxt = ltype_r; out_nxt = out_r; out_clr = '0;
    omsk = wd[cqt_pkg::AM_LSB +: cqt_pkg::NL];
    push = 1'b0; start_dir = 1'b0; purge = 1'b0;
    if (acc) begin
      case (wb_adr_i)
        cqt_pkg::A_CMD: begin
          if (!wb_we_i) begin
            dat_nxt = {23'h0, res_r};
          end else if (dir_r) begin
            ack_nxt = st_r == cqt_pkg::E_IDLE;
            dir_nxt = st_r != cqt_pkg::E_IDLE;
          end else if (c_flg[cqt_pkg::F_IDLE] && pending) begin
            res_nxt = {1'b1, hcnt_r};
          end else if (c_flg[cqt_pkg::F_DEF] && c_op != cqt_pkg::OP_CONFIG) begin
            ack_nxt = ~q_full;
            push    = ~q_full;
            if (!q_full) begin
              res_nxt  = {1'b0, hcnt_r};
              hcnt_nxt = hcnt_r + 1'b1;
            end
          end else begin
            ack_nxt   = 1'b0;
            start_dir = ~pending;
            dir_nxt   = ~pending;
            if (!pending) begin
              res_nxt  = {1'b0, hcnt_r};
              hcnt_nxt = hcnt_r + 1'b1;
            end
          end
        end
        cqt_pkg::A_RES:  dat_nxt = {23'h0, res_r};
        cqt_pkg::A_DONE: dat_nxt = {24'h0, done_r};
        cqt_pkg::A_STAT: dat_nxt = {7'h0, pending, 4'h0, cnt_r, 6'h0, steer_r,
                                    {(8 - cqt_pkg::NL){1'b0}}, line_st};
        cqt_pkg::A_LTYPE: begin
          dat_nxt = {30'h0, ltype_r};
          if (wb_we_i) begin
            ack_nxt = ~pending;
            if (!pending) ltype_nxt = wd[1:0];
          end
        end
        cqt_pkg::A_OUT: begin
          dat_nxt = {{(32 - cqt_pkg::NL){1'b0}}, out_r};
          if (wb_we_i) begin
            if (omsk == '0) begin
              res_nxt = {1'b1, hcnt_r};
            end else begin
              res_nxt = {1'b0, hcnt_r};
              out_nxt = (out_r & ~omsk) | (wd[cqt_pkg::AV_LSB +: cqt_pkg::NL] & omsk);
              if (wd[cqt_pkg::O_CLR]) out_clr = omsk;
            end
          end
        end
        cqt_pkg::A_PURGE: purge = wb_we_i;
        default: dat_nxt = 32'h0;
      endcase
    end
    if (purge) dir_nxt = 1'b0;
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = purge ? '0 : cnt_r + {{cqt_pkg::QAW{1'b0}}, push}
                            - {{cqt_pkg::QAW{1'b0}}, pop};
    if (purge) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end
  end

  // Register bus and queue state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0; dat_r <= 32'h0; res_r <= '0; dir_r <= 1'b0;
      hcnt_r <= '0; ltype_r <= cqt_pkg::DT_LEVEL; out_r <= '0;
      wp_r <= '0; rp_r <= '0; cnt_r <= '0;
    end else begin
      ack_r <= ack_nxt; dat_r <= dat_nxt; res_r <= res_nxt; dir_r <= dir_nxt;
      hcnt_r <= hcnt_nxt; ltype_r <= ltype_nxt; out_r <= out_nxt;
      wp_r <= wp_nxt; rp_r <= rp_nxt; cnt_r <= cnt_nxt;
    end
  end

  // Queue storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) q_mem[wp_r] <= {c_flg, c_op, wd[cqt_pkg::ARG_LSB +: cqt_pkg::AW], hcnt_r};
  end

  // ========================================================================
  // Execution engine
  assign ld    = start_dir ? {c_flg, c_op, wd[cqt_pkg::ARG_LSB +: cqt_pkg::AW], hcnt_r}
                           : q_mem[rp_r];
  assign e_flg = e_r[EW-1 -: cqt_pkg::FLW];
  assign e_op  = e_r[EW-cqt_pkg::FLW-1 -: 4];
  assign e_arg = e_r[cqt_pkg::HW +: cqt_pkg::AW];
  assign adj   = e_op == cqt_pkg::OP_BRIGHT || e_op == cqt_pkg::OP_CONTR;
  // Picture adjust always starts on any field
  assign fld_ok = adj || (e_flg[cqt_pkg::F_EVEN] ? ~field_odd_i :
                          e_flg[cqt_pkg::F_ODD] ? field_odd_i : 1'b1);
  // Event condition from local or other board lines
  assign src  = e_flg[cqt_pkg::F_REM] ? remote_state_i : line_st;
  assign want = e_arg[cqt_pkg::AV_LSB +: cqt_pkg::NL];
  assign msk  = (st_r == cqt_pkg::E_EVT) ? e_arg[cqt_pkg::AM_LSB +: cqt_pkg::NL] : '0;
  assign sat  = ~(src ^ want) & msk;
  assign hits = src & msk;
  assign released = (e_op == cqt_pkg::OP_WALL) ? (msk != '0 && sat == msk)
                                               : (sat != '0);

  // Next state of the engine and its outputs
  always_comb begin
    st_nxt = st_r; e_nxt = e_r; fld_nxt = fld_r; steer_nxt = steer_r;
    dest_nxt = dest_r; cam_nxt = cam_r; bri_nxt = bri_r; con_nxt = con_r;
    csel_nxt = csel_r; cval_nxt = cval_r; cont_nxt = cont_r; done_nxt = done_r;
    go_nxt = 1'b0; cfgwe_nxt = 1'b0; rclr_nxt = '0; eng_clr = '0;
    case (st_r)
      cqt_pkg::E_IDLE: begin
        if (pop || start_dir) begin
          e_nxt = ld;
          if (ld[EW-cqt_pkg::FLW-1 -: 4] == cqt_pkg::OP_CONFIG) begin
            cfgwe_nxt = 1'b1;
            csel_nxt  = ld[cqt_pkg::HW + cqt_pkg::AM_LSB +: 4];
            cval_nxt  = ld[cqt_pkg::HW + cqt_pkg::AV_LSB +: 8];
            done_nxt  = ld[cqt_pkg::HW-1:0];
          end else if (ld[EW-cqt_pkg::FLW-1 -: 4] == cqt_pkg::OP_WANY ||
                       ld[EW-cqt_pkg::FLW-1 -: 4] == cqt_pkg::OP_WALL) begin
            st_nxt = cqt_pkg::E_EVT;
          end else begin
            st_nxt = cqt_pkg::E_SYNC;
          end
        end
      end
      cqt_pkg::E_SYNC: begin
        if (field_start_i && fld_ok) begin
          st_nxt  = cqt_pkg::E_RUN;
          fld_nxt = e_flg[cqt_pkg::F_ONE] ? cqt_pkg::FLD_ONE : cqt_pkg::FLD_FULL;
          case (e_op)
            cqt_pkg::OP_CAPT, cqt_pkg::OP_CONT, cqt_pkg::OP_SCAPT: begin
              go_nxt   = 1'b1;
              cont_nxt = e_op == cqt_pkg::OP_CONT;
              dest_nxt = (e_op == cqt_pkg::OP_SCAPT) ? steer_r : e_arg[1:0];
            end
            cqt_pkg::OP_CAM:    cam_nxt = e_arg[1:0];
            cqt_pkg::OP_SCAM:   cam_nxt = steer_r;
            cqt_pkg::OP_BRIGHT: bri_nxt = e_arg[7:0];
            cqt_pkg::OP_CONTR:  con_nxt = e_arg[7:0];
            default:            cont_nxt = 1'b0;
          endcase
          if (e_op == cqt_pkg::OP_CAM || e_op == cqt_pkg::OP_SCAM || adj) begin
            st_nxt   = cqt_pkg::E_IDLE;
            done_nxt = e_r[cqt_pkg::HW-1:0];
          end
        end
      end
      cqt_pkg::E_RUN: begin
        if (field_start_i) begin
          fld_nxt = fld_r - 1'b1;
          if (fld_r == cqt_pkg::FLD_ONE) begin
            st_nxt   = cqt_pkg::E_IDLE;
            cont_nxt = 1'b0;
            done_nxt = e_r[cqt_pkg::HW-1:0];
          end
        end
      end
      cqt_pkg::E_EVT: begin
        if (released) begin
          st_nxt   = cqt_pkg::E_IDLE;
          done_nxt = e_r[cqt_pkg::HW-1:0];
          if (hits != '0) steer_nxt = hi_line(hits);
          eng_clr = (e_op == cqt_pkg::OP_WALL) ? msk
                  : ((hits != '0) ? (cqt_pkg::NL'(1) << hi_line(hits)) : '0);
          if (e_flg[cqt_pkg::F_REM]) begin
            rclr_nxt = eng_clr;
            eng_clr  = '0;
          end
        end
      end
      default: st_nxt = cqt_pkg::E_IDLE;
    endcase
    if (purge) begin
      st_nxt   = cqt_pkg::E_IDLE;
      cont_nxt = 1'b0;
      go_nxt   = 1'b0;
    end
  end

  // Engine registers; reset clears steer and aborts work
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= cqt_pkg::E_IDLE; e_r <= '0; fld_r <= 2'h0; steer_r <= 2'h0;
      dest_r <= 2'h0; cam_r <= 2'h0; bri_r <= 8'h0; con_r <= 8'h0;
      csel_r <= 4'h0; cval_r <= 8'h0; cont_r <= 1'b0; done_r <= '0;
      go_r <= 1'b0; cfgwe_r <= 1'b0; rclr_r <= '0; busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt; e_r <= e_nxt; fld_r <= fld_nxt; steer_r <= steer_nxt;
      dest_r <= dest_nxt; cam_r <= cam_nxt; bri_r <= bri_nxt; con_r <= con_nxt;
      csel_r <= csel_nxt; cval_r <= cval_nxt; cont_r <= cont_nxt; done_r <= done_nxt;
      go_r <= go_nxt; cfgwe_r <= cfgwe_nxt; rclr_r <= rclr_nxt;
      busy_r <= (cnt_nxt != '0) | (st_nxt != cqt_pkg::E_IDLE);
    end
  end

  // Outputs straight from flops
  assign wb_ack_o = ack_r;          assign wb_dat_o = dat_r;
  assign capture_go_o = go_r;       assign capture_dest_o = dest_r;
  assign capture_cont_o = cont_r;   assign cam_sel_o = cam_r;
  assign bright_o = bri_r;          assign contrast_o = con_r;
  assign cfg_we_o = cfgwe_r;        assign cfg_sel_o = csel_r;
  assign cfg_val_o = cval_r;        assign out_line_o = out_r;
  assign remote_clr_o = rclr_r;     assign busy_o = busy_r;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic cmd_w;
  assign cmd_w = acc & wb_we_i & (wb_adr_i == cqt_pkg::A_CMD) & ~dir_r;
  sequence s_ack_fail;
    wb_ack_o && res_r[cqt_pkg::RES_FAIL];
  endsequence
  sequence s_ack_ok;
    wb_ack_o && !res_r[cqt_pkg::RES_FAIL];
  endsequence

  chk_idle_fail: assert property (
    cmd_w && c_flg[cqt_pkg::F_IDLE] && pending |=> s_ack_fail)
    else $error("only-if-idle not refused");
  chk_defer_ack: assert property (
    cmd_w && c_flg[cqt_pkg::F_DEF] && !c_flg[cqt_pkg::F_IDLE] && c_op != cqt_pkg::OP_CONFIG
    && !q_full |=> s_ack_ok ##0 cnt_r != '0)
    else $error("deferred command not queued at once");
  chk_block_wait: assert property (
    dir_r && st_r != cqt_pkg::E_IDLE |=> !wb_ack_o)
    else $error("blocking command acked early");
  chk_full_hold: assert property (
    cmd_w && c_flg[cqt_pkg::F_DEF] && c_op != cqt_pkg::OP_CONFIG && q_full
    && !(c_flg[cqt_pkg::F_IDLE]) |=> !wb_ack_o && cnt_r <= $past(cnt_r))
    else $error("full queue took a command");
  chk_all_hold: assert property (
    st_r == cqt_pkg::E_EVT && e_op == cqt_pkg::OP_WALL && sat != msk && !purge
    |=> st_r == cqt_pkg::E_EVT)
    else $error("all-line wait released early");
  chk_evt_release: assert property (
    st_r == cqt_pkg::E_EVT && released && hits != '0 && !purge
    |=> st_r == cqt_pkg::E_IDLE && steer_r == $past(hi_line(hits)))
    else $error("wait release wrong");
  chk_field_start: assert property (
    st_r == cqt_pkg::E_SYNC && field_start_i && !adj && e_flg[cqt_pkg::F_EVEN]
    && field_odd_i && !purge |=> st_r == cqt_pkg::E_SYNC)
    else $error("started on wrong field");
  chk_one_field: assert property (
    capture_go_o && e_flg[cqt_pkg::F_ONE] |-> fld_r == cqt_pkg::FLD_ONE)
    else $error("single field span wrong");
  chk_out_mask: assert property (
    acc && wb_we_i && wb_adr_i == cqt_pkg::A_OUT && wd[cqt_pkg::AM_LSB +: cqt_pkg::NL] == '0
    |=> s_ack_fail ##0 out_line_o == $past(out_line_o))
    else $error("zero mask output write not failed");
  chk_purge_flush: assert property (
    purge |=> cnt_r == '0 && st_r == cqt_pkg::E_IDLE ##1 !busy_o)
    else $error("purge left work");
  chk_steer_reset: assert property (disable iff (1'b0)
    rst_i |=> steer_r == 2'h0 && cnt_r == '0)
    else $error("reset left steer or queue");
endmodule

// ==== core/cqt_pkg.sv ====
/*
  Constants for the capture command queue and trigger block.
  Assumes a 32-bit classic Wishbone register bus and one system clock.
*/
// ==========================================================================
// Package
package cqt_pkg;
  // Sizes
  localparam int NL   = 1;               // Digital input lines
  localparam int QD   = 8;               // Queue depth in entries
  localparam int QAW  = 3;               // Queue pointer width
  localparam int HW   = 8;               // Handle width
  localparam int FLW  = 6;               // Stored flag bits
  localparam int AW   = 16;              // Command operand width

  // Register byte offsets
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_RES   = 8'h04;
  localparam logic [7:0] A_DONE  = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0C;
  localparam logic [7:0] A_LTYPE = 8'h10;
  localparam logic [7:0] A_OUT   = 8'h14;
  localparam logic [7:0] A_PURGE = 8'h18;

  // Command word layout
  localparam int OP_LSB  = 0;
  localparam int FL_LSB  = 4;
  localparam int ARG_LSB = 16;
  localparam int F_EVEN  = 0;            // even_field_start
  localparam int F_ODD   = 1;            // odd_field_start
  localparam int F_ONE   = 2;            // one_field_only
  localparam int F_IDLE  = 3;            // Only if idle
  localparam int F_DEF   = 4;            // Deferred
  localparam int F_REM   = 5;            // Watch the second board
  localparam int AV_LSB  = 0;            // Value / wanted state / index
  localparam int AM_LSB  = 8;            // Mask / config selector

  // Opcodes
  localparam logic [3:0] OP_CAPT   = 4'h0;
  localparam logic [3:0] OP_CONT   = 4'h1;
  localparam logic [3:0] OP_SCAPT  = 4'h2;
  localparam logic [3:0] OP_CAM    = 4'h3;
  localparam logic [3:0] OP_SCAM   = 4'h4;
  localparam logic [3:0] OP_BRIGHT = 4'h5;
  localparam logic [3:0] OP_CONTR  = 4'h6;
  localparam logic [3:0] OP_FWAIT  = 4'h7;
  localparam logic [3:0] OP_WANY   = 4'h8;
  localparam logic [3:0] OP_WALL   = 4'h9;
  localparam logic [3:0] OP_CONFIG = 4'hA;

  // Line detection types
  localparam logic [1:0] DT_LEVEL = 2'h0;
  localparam logic [1:0] DT_RISE  = 2'h1;
  localparam logic [1:0] DT_FALL  = 2'h2;

  // Readback fields
  localparam int RES_FAIL  = 8;
  localparam int ST_STEER  = 8;
  localparam int ST_CNT    = 16;
  localparam int ST_BUSY   = 24;
  localparam int O_CLR     = 16;

  // Field counts
  localparam logic [1:0] FLD_FULL = 2'h2;
  localparam logic [1:0] FLD_ONE  = 2'h1;

  typedef enum {E_IDLE, E_SYNC, E_RUN, E_EVT} cqt_eng_e;
endpackage

// ==== tb/capture_command_queue_trigger_bench.sv ====
/*
  Self-checking bench for the command queue and trigger block.
  Assumes the field source model and the Wishbone map of the core.
*/
module capture_command_queue_trigger_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, trig = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic        ack, fs, fo, go;
  logic [1:0]  dest;
  logic        outl, busy;
  int          bad_count = 0, cmp_count = 0, n;
  // ==========================================================
  // Clock, field source and block
  always #2 clk_i = ~clk_i;
  cqt_field_gen fld_u (.clk_i(clk_i), .rst_i(rst_i), .start_o(fs), .odd_o(fo));
  cqt_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .trig_i(trig), .remote_state_i(1'b0), .field_start_i(fs),
    .field_odd_i(fo), .capture_go_o(go), .capture_dest_o(dest), .capture_cont_o(),
    .cam_sel_o(), .bright_o(), .contrast_o(), .cfg_we_o(), .cfg_sel_o(), .cfg_val_o(),
    .out_line_o(outl), .remote_clr_o(), .busy_o(busy));
  // ==========================================================
  // Shared tasks; bus request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 3000);
    q = rdat;
    cyc <= 0; stb <= 0;
    chk(n < 3000, 1);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a capture start; the parity is kept in q
  task automatic wait_go(input int lim);
    n = 0;
    do @(posedge clk_i); while (go !== 1'b1 && ++n < lim);
    q = {30'h0, dest[0], fo};
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    wb(0, 8'h0C, 0); chk(q & 32'h300, 32'h0);
    wb(0, 8'h10, 0); chk(q & 32'h3, 32'h0);
    wb(0, 8'h1C, 0); chk(q, 32'h0);
    $display("reset test done");
  endtask
  // Deferred capture on even then odd field, acked at once
  task automatic t_defer;
    for (int p = 0; p < 2; p++) begin
      wb(1, 8'h00, 32'h0000_0100 | (32'h0000_0010 << p));
      chk(n < 3, 1);
      wait_go(300); chk(n < 300, 1); chk(q[0], p);
    end
    $display("deferred test done");
  endtask
  // Only-if-idle refused while a deferred field wait is queued behind the running capture
  task automatic t_idle;
    wb(1, 8'h00, 32'h0000_0107);
    wb(1, 8'h00, 32'h0000_0080);
    wb(0, 8'h04, 0); chk(q[8], 1);
    $display("idle test done");
  endtask
  // Trigger releases queued any-line wait, then steered capture
  task automatic t_event;
    wb(1, 8'h00, 32'h0101_0108);
    wb(1, 8'h00, 32'h0000_0102);
    wait_go(150); chk(n < 150, 0);
    trig <= 1;
    wait_go(300); chk(n < 300, 1); chk(q[1], 0);
    trig <= 0;
    wb(0, 8'h0C, 0); chk(q & 32'h300, 32'h0);
    $display("event test done");
  endtask
  // Output write: zero mask fails, mask one drives the line
  task automatic t_out;
    wb(1, 8'h14, 32'h0000_0001); wb(0, 8'h04, 0); chk(q[8], 1);
    chk(outl, 0);
    wb(1, 8'h14, 32'h0000_0101); chk(outl, 1);
    $display("output test done");
  endtask
  // Ten one-field waits overrun the queue; host stalls, purge empties it
  task automatic t_fill;
    for (int k = 0; k < 10; k++) begin
      wb(1, 8'h00, 32'h0000_0147);
    end
    chk(n > 2, 1);
    wb(0, 8'h0C, 0);
    chk(q[19:16], 8);
    chk(busy, 1);
    wb(1, 8'h18, 0);
    wb(0, 8'h0C, 0);
    chk(q[24:16], 0);
    chk(busy, 0);
    $display("queue test done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    t_reset; t_defer; t_idle; t_event; t_out; t_fill;
    finish_test;
  end
  initial begin
    #100000;
    bad_count++;
    finish_test;
  end
endmodule

// ==== tb/cqt_field_gen.sv ====
/*
  Video field timing source standing in for the camera side.
  Assumes one clock shared with the block under test.
*/
module cqt_field_gen #(
  parameter int PER = 40           // Cycles per field
) (
  input  wire logic clk_i,         // System clock
  input  wire logic rst_i,         // Sync reset, high
  output logic      start_o,       // Field start pulse
  output logic      odd_o          // Parity of field
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  // Pulse every PER cycles, parity flips with each field
  always_ff @(posedge clk_i) begin
    cnt_r   <= (rst_i || cnt_r == 8'(PER - 1)) ? 8'h00 : cnt_r + 8'h01;
    start_o <= !rst_i && cnt_r == 8'(PER - 1);
    odd_o   <= rst_i ? 1'b0 : odd_o ^ (cnt_r == 8'(PER - 1));
  end
endmodule
